// [dtg_map.vh]
// Register offsets, field positions, reset values and timing counts for the guard
`ifndef DTG_MAP_VH
`define DTG_MAP_VH

// Clock rate of mclk
`define DTG_CLK_MHZ 100

// Command type codes presented by the scheduler
`define DTG_CMD_ACT 2'h0
`define DTG_CMD_RD 2'h1
`define DTG_CMD_WR 2'h2
`define DTG_CMD_REF 2'h3

// Register byte offsets
`define DTG_OFF_ACT 8'h00
`define DTG_OFF_FAW 8'h04
`define DTG_OFF_CCD 8'h08
`define DTG_OFF_WTR 8'h0C
`define DTG_OFF_RFC 8'h10
`define DTG_OFF_REFI 8'h14
`define DTG_OFF_STAT 8'h18
`define DTG_OFF_CTRL 8'h1C

// Field positions (low bit of each field)
`define DTG_F_LO0 0
`define DTG_F_LO1 8
`define DTG_F_LO2 16
`define DTG_F_STAT_BLK 8
`define DTG_F_STAT_OWED 16

// Times as printed, in their own units
`define DTG_FAW_TIME_NS 30
`define DTG_RFC_TIME_NS 350
`define DTG_RFCX_TIME_NS 120
`define DTG_REFI_TIME_US 8

// Cycle counts: least times round up, the longest time rounds down
`define DTG_FAW_CYC ((`DTG_FAW_TIME_NS * `DTG_CLK_MHZ + 999) / 1000)
`define DTG_RFC_CYC ((`DTG_RFC_TIME_NS * `DTG_CLK_MHZ + 999) / 1000)
`define DTG_RFCX_CYC ((`DTG_RFCX_TIME_NS * `DTG_CLK_MHZ + 999) / 1000)
`define DTG_REFI_CYC (`DTG_REFI_TIME_US * `DTG_CLK_MHZ)

// Reset values of the cycle-count registers
`define DTG_RST_RRD_S 8'h04
`define DTG_RST_RRD_L 8'h06
`define DTG_RST_RRD_X 8'h04
`define DTG_RST_FAWX 8'h10
`define DTG_RST_CCD_S 8'h04
`define DTG_RST_CCD_L 8'h06
`define DTG_RST_WTR_S 8'h03
`define DTG_RST_WTR_L 8'h08
`define DTG_RST_WEND 8'h0C
`define DTG_RST_CTRL 1'h1

`endif

// [dtg_down_counter.v]
// Loadable saturating down-counter that reports when its interval has run out
`timescale 1ns/100ps
module dtg_down_counter #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire load,
  input wire [W-1:0] value,
  output wire idle
);
  // Remaining cycles of the interval
  reg [W-1:0] cnt_q;

  // Load value minus one so that the next command lands exactly value cycles later
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= (value == {W{1'b0}}) ? {W{1'b0}} : value - 1'b1;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign idle = (cnt_q == {W{1'b0}});
endmodule

// [dtg_faw_window.v]
// Sliding window tracker that allows at most four activates per window
`timescale 1ns/100ps
module dtg_faw_window #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire act,
  input wire [W-1:0] window,
  output wire room
);
  // One slot per activate still inside the window
  reg [W-1:0] slot_q [0:3];
  // One-hot choice of the first free slot
  reg [3:0] pick;
  // Free slots
  wire [3:0] free;
  integer i;

  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_free
      assign free[s] = (slot_q[s] == {W{1'b0}});
    end
  endgenerate

  // Lowest free slot wins
  always @* begin
    pick = 4'h0;
    if (free[0]) begin
      pick = 4'h1;
    end else if (free[1]) begin
      pick = 4'h2;
    end else if (free[2]) begin
      pick = 4'h4;
    end else if (free[3]) begin
      pick = 4'h8;
    end
  end

  // Each slot ages out one cycle at a time; a new activate claims a free slot
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        slot_q[i] <= {W{1'b0}};
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (act && pick[i]) begin
          slot_q[i] <= (window == {W{1'b0}}) ? {W{1'b0}} : window - 1'b1;
        end else if (!free[i]) begin
          slot_q[i] <= slot_q[i] - 1'b1;
        end
      end
    end
  end

  // A fifth activate waits until the oldest one leaves the window
  assign room = |free;
endmodule

// [dtg_timing_guard.v]
// Command spacing guard between the scheduler and a DDR4 command bus
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "dtg_map.vh"

// How it works
// - Activates to other groups wait short spacing
// - Activates to same group wait long spacing
// - Activates to other rank wait cross-rank spacing
// - At most four activates per rank window
// - At most four activates per device window
// - Column commands, other group, short spacing
// - Column commands, same group, long spacing
// - Read other group waits short write-recovery
// - Read same group waits long write-recovery
// - Refresh blocks activates to rank for cycle
// - Refresh blocks other-rank activates, cross-rank time
// - Refresh owed each interval, average kept
module dtg_timing_guard #(
  parameter RW = 1,
  parameter GW = 2
) (
  mclk, nrst,
  psel, penable, pwrite, paddr, pwdata, prdata, pready, pslverr,
  cmd_valid, cmd_type, cmd_rank, cmd_group,
  issue_valid_q, issue_type_q, issue_rank_q, issue_group_q,
  refresh_due_q
);
  localparam RANKS = 1 << RW;
  localparam GROUPS = 1 << GW;
  localparam [31:0] FAW_CYC = `DTG_FAW_CYC;
  localparam [31:0] RFC_CYC = `DTG_RFC_CYC;
  localparam [31:0] RFCX_CYC = `DTG_RFCX_CYC;
  localparam [31:0] REFI_CYC = `DTG_REFI_CYC;

  input wire mclk;
  input wire nrst;
  // APB slave
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  // Request from the scheduler, held until issued
  input wire cmd_valid;
  input wire [1:0] cmd_type;
  input wire [RW-1:0] cmd_rank;
  input wire [GW-1:0] cmd_group;
  // Command sent toward the memory, also the acknowledge
  output reg issue_valid_q;
  output reg [1:0] issue_type_q;
  output reg [RW-1:0] issue_rank_q;
  output reg [GW-1:0] issue_group_q;
  // Ranks with refresh owed
  output reg [RANKS-1:0] refresh_due_q;

  // Activate spacing: short, long, cross-rank
  reg [23:0] cfg_act_q;
  // Four-activate windows: per rank, per device
  reg [15:0] cfg_faw_q;
  // Column spacing: short, long
  reg [15:0] cfg_ccd_q;
  // Write-to-read: short, long, last data beat after write
  reg [23:0] cfg_wtr_q;
  // Refresh cycle times, per rank and cross-rank
  reg [11:0] cfg_rfc_q;
  reg [11:0] cfg_rfcx_q;
  // Refresh interval
  reg [15:0] cfg_refi_q;
  // Refresh bookkeeping enable
  reg cfg_en_q;

  // Skip cycle after each issue, since the acknowledge lands one cycle late
  reg hold_q;
  // Request seen but held back
  reg blocked_q;
  // Rank of the last activate and last refresh
  reg [RW-1:0] last_act_rank_q;
  reg [RW-1:0] last_ref_rank_q;
  // Refreshes owed per rank
  reg [3:0] owed_q [0:RANKS-1];
  reg [3:0] owed_d [0:RANKS-1];

  // Counter status
  wire [RANKS-1:0] rrd_s_idle;
  wire [RANKS*GROUPS-1:0] rrd_l_idle;
  wire [RANKS-1:0] rfc_idle;
  wire [RANKS-1:0] refi_idle;
  wire [RANKS-1:0] faw_room;
  wire [GROUPS-1:0] ccd_l_idle;
  wire [GROUPS-1:0] wtr_l_idle;
  wire rrd_x_idle;
  wire rfc_x_idle;
  wire faw_x_room;
  wire ccd_s_idle;
  wire wtr_s_idle;

  // Decisions
  reg cmd_ok;
  wire grant_d;
  wire act_go;
  wire col_go;
  wire wr_go;
  wire ref_go;
  wire [8:0] wtr_s_span;
  wire [8:0] wtr_l_span;
  wire apb_fire;
  reg [31:0] rdata_d;
  integer k, j;

  // Register decode shared by the read and write paths
  function reg_known;
    input [7:0] a;
    begin
      case (a)
        `DTG_OFF_ACT, `DTG_OFF_FAW, `DTG_OFF_CCD, `DTG_OFF_WTR,
        `DTG_OFF_RFC, `DTG_OFF_REFI, `DTG_OFF_STAT, `DTG_OFF_CTRL: reg_known = 1'b1;
        default: reg_known = 1'b0;
      endcase
    end
  endfunction

  // One wait state: pready rises at the end of the first access cycle and drops after the handshake
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~reg_known(paddr);
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // Transfer completes on the edge where pready is seen high
  assign apb_fire = psel & penable & pready;

  // Read mux; reserved bits and unmapped offsets read zero
  always @* begin
    rdata_d = 32'h0;
    case (paddr)
      `DTG_OFF_ACT: rdata_d = {8'h0, cfg_act_q};
      `DTG_OFF_FAW: rdata_d = {16'h0, cfg_faw_q};
      `DTG_OFF_CCD: rdata_d = {16'h0, cfg_ccd_q};
      `DTG_OFF_WTR: rdata_d = {8'h0, cfg_wtr_q};
      `DTG_OFF_RFC: rdata_d = {4'h0, cfg_rfcx_q, 4'h0, cfg_rfc_q};
      `DTG_OFF_REFI: rdata_d = {16'h0, cfg_refi_q};
      `DTG_OFF_STAT: begin
        rdata_d[RANKS-1:0] = refresh_due_q;
        rdata_d[`DTG_F_STAT_BLK] = blocked_q;
        rdata_d[`DTG_F_STAT_OWED+3:`DTG_F_STAT_OWED] = owed_q[0];
      end
      `DTG_OFF_CTRL: rdata_d = {31'h0, cfg_en_q};
      default: rdata_d = 32'h0;
    endcase
  end

  // Configuration writes; a slip in offset is answered with pslverr and ignored
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_act_q <= {`DTG_RST_RRD_X, `DTG_RST_RRD_L, `DTG_RST_RRD_S};
      cfg_faw_q <= {`DTG_RST_FAWX, FAW_CYC[7:0]};
      cfg_ccd_q <= {`DTG_RST_CCD_L, `DTG_RST_CCD_S};
      cfg_wtr_q <= {`DTG_RST_WEND, `DTG_RST_WTR_L, `DTG_RST_WTR_S};
      cfg_rfc_q <= RFC_CYC[11:0];
      cfg_rfcx_q <= RFCX_CYC[11:0];
      cfg_refi_q <= REFI_CYC[15:0];
      cfg_en_q <= `DTG_RST_CTRL;
    end else if (apb_fire && pwrite) begin
      case (paddr)
        `DTG_OFF_ACT: cfg_act_q <= pwdata[23:0];
        `DTG_OFF_FAW: cfg_faw_q <= pwdata[15:0];
        `DTG_OFF_CCD: cfg_ccd_q <= pwdata[15:0];
        `DTG_OFF_WTR: cfg_wtr_q <= pwdata[23:0];
        `DTG_OFF_RFC: begin
          cfg_rfc_q <= pwdata[11:0];
          cfg_rfcx_q <= pwdata[27:16];
        end
        `DTG_OFF_REFI: cfg_refi_q <= pwdata[15:0];
        `DTG_OFF_CTRL: cfg_en_q <= pwdata[0];
        default: cfg_en_q <= cfg_en_q;
      endcase
    end
  end

  // Per-rank trackers, then per-group column trackers
  genvar r, g;
  generate
    for (r = 0; r < RANKS; r = r + 1) begin : g_rank
      // Any activate in this rank opens the short spacing
      dtg_down_counter #(.W(8)) u_rrd_s (
        .mclk(mclk),
        .nrst(nrst),
        .load(act_go && cmd_rank == r),
        .value(cfg_act_q[`DTG_F_LO0+7:`DTG_F_LO0]),
        .idle(rrd_s_idle[r])
      );
      // Refresh busy time of this rank
      dtg_down_counter #(.W(12)) u_rfc (
        .mclk(mclk),
        .nrst(nrst),
        .load(ref_go && cmd_rank == r),
        .value(cfg_rfc_q),
        .idle(rfc_idle[r])
      );
      // Free-running refresh interval tick
      dtg_down_counter #(.W(16)) u_refi (
        .mclk(mclk),
        .nrst(nrst),
        .load(refi_idle[r]),
        .value(cfg_refi_q),
        .idle(refi_idle[r])
      );
      // Four-activate window of this rank
      dtg_faw_window #(.W(8)) u_faw (
        .mclk(mclk),
        .nrst(nrst),
        .act(act_go && cmd_rank == r),
        .window(cfg_faw_q[`DTG_F_LO0+7:`DTG_F_LO0]),
        .room(faw_room[r])
      );
      for (g = 0; g < GROUPS; g = g + 1) begin : g_grp
        // Same-group activate spacing within the rank
        dtg_down_counter #(.W(8)) u_rrd_l (
          .mclk(mclk),
          .nrst(nrst),
          .load(act_go && cmd_rank == r && cmd_group == g),
          .value(cfg_act_q[`DTG_F_LO1+7:`DTG_F_LO1]),
          .idle(rrd_l_idle[r*GROUPS+g])
        );
      end
    end
    for (g = 0; g < GROUPS; g = g + 1) begin : g_col
      // Same-group column spacing
      dtg_down_counter #(.W(8)) u_ccd_l (
        .mclk(mclk),
        .nrst(nrst),
        .load(col_go && cmd_group == g),
        .value(cfg_ccd_q[`DTG_F_LO1+7:`DTG_F_LO1]),
        .idle(ccd_l_idle[g])
      );
      // Same-group write recovery, counted past the last data beat
      dtg_down_counter #(.W(9)) u_wtr_l (
        .mclk(mclk),
        .nrst(nrst),
        .load(wr_go && cmd_group == g),
        .value(wtr_l_span),
        .idle(wtr_l_idle[g])
      );
    end
  endgenerate

  // Device-wide trackers
  dtg_down_counter #(.W(8)) u_rrd_x (
    .mclk(mclk),
    .nrst(nrst),
    .load(act_go),
    .value(cfg_act_q[`DTG_F_LO2+7:`DTG_F_LO2]),
    .idle(rrd_x_idle)
  );
  dtg_down_counter #(.W(12)) u_rfc_x (
    .mclk(mclk),
    .nrst(nrst),
    .load(ref_go),
    .value(cfg_rfcx_q),
    .idle(rfc_x_idle)
  );
  dtg_faw_window #(.W(8)) u_faw_x (
    .mclk(mclk),
    .nrst(nrst),
    .act(act_go),
    .window(cfg_faw_q[`DTG_F_LO1+7:`DTG_F_LO1]),
    .room(faw_x_room)
  );
  dtg_down_counter #(.W(8)) u_ccd_s (
    .mclk(mclk),
    .nrst(nrst),
    .load(col_go),
    .value(cfg_ccd_q[`DTG_F_LO0+7:`DTG_F_LO0]),
    .idle(ccd_s_idle)
  );
  dtg_down_counter #(.W(9)) u_wtr_s (
    .mclk(mclk),
    .nrst(nrst),
    .load(wr_go),
    .value(wtr_s_span),
    .idle(wtr_s_idle)
  );

  // Write recovery starts at the edge after the last beat, so add the beat offset
  assign wtr_s_span = {1'b0, cfg_wtr_q[`DTG_F_LO2+7:`DTG_F_LO2]} +
                      {1'b0, cfg_wtr_q[`DTG_F_LO0+7:`DTG_F_LO0]};
  assign wtr_l_span = {1'b0, cfg_wtr_q[`DTG_F_LO2+7:`DTG_F_LO2]} +
                      {1'b0, cfg_wtr_q[`DTG_F_LO1+7:`DTG_F_LO1]};

  // Permission check for the waiting request
  always @* begin
    cmd_ok = 1'b0;
    case (cmd_type)
      `DTG_CMD_ACT: begin
        cmd_ok = rrd_s_idle[cmd_rank] & rrd_l_idle[{cmd_rank, cmd_group}] &
                 (rrd_x_idle | last_act_rank_q == cmd_rank) &
                 faw_room[cmd_rank] & faw_x_room &
                 rfc_idle[cmd_rank] &
                 (rfc_x_idle | last_ref_rank_q == cmd_rank);
      end
      `DTG_CMD_RD: begin
        cmd_ok = ccd_s_idle & ccd_l_idle[cmd_group] &
                 wtr_s_idle & wtr_l_idle[cmd_group];
      end
      `DTG_CMD_WR: begin
        cmd_ok = ccd_s_idle & ccd_l_idle[cmd_group];
      end
      `DTG_CMD_REF: begin
        // Back-to-back refreshes to a rank also respect its busy time
        cmd_ok = rfc_idle[cmd_rank];
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // Stall the scheduler until every counter in play has expired
  assign grant_d = cmd_valid & ~hold_q & cmd_ok;
  assign act_go = grant_d & (cmd_type == `DTG_CMD_ACT);
  assign wr_go = grant_d & (cmd_type == `DTG_CMD_WR);
  assign col_go = grant_d & (cmd_type == `DTG_CMD_RD || cmd_type == `DTG_CMD_WR);
  assign ref_go = grant_d & (cmd_type == `DTG_CMD_REF);

  // Issue register; it doubles as the acknowledge to the scheduler
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      issue_valid_q <= 1'b0;
      issue_type_q <= `DTG_CMD_ACT;
      issue_rank_q <= {RW{1'b0}};
      issue_group_q <= {GW{1'b0}};
      hold_q <= 1'b0;
      blocked_q <= 1'b0;
      last_act_rank_q <= {RW{1'b0}};
      last_ref_rank_q <= {RW{1'b0}};
    end else begin
      issue_valid_q <= grant_d;
      hold_q <= grant_d;
      blocked_q <= cmd_valid & ~hold_q & ~cmd_ok;
      if (grant_d) begin
        issue_type_q <= cmd_type;
        issue_rank_q <= cmd_rank;
        issue_group_q <= cmd_group;
      end
      if (act_go) begin
        last_act_rank_q <= cmd_rank;
      end
      if (ref_go) begin
        last_ref_rank_q <= cmd_rank;
      end
    end
  end

  // Owed refreshes: each interval tick adds one, each refresh pays one
  always @* begin
    for (k = 0; k < RANKS; k = k + 1) begin
      owed_d[k] = owed_q[k];
      // Tick and payment in the same cycle cancel, so neither is lost
      if (cfg_en_q && refi_idle[k] && owed_q[k] != 4'hF) begin
        owed_d[k] = owed_d[k] + 4'h1;
      end
      if (ref_go && cmd_rank == k && owed_d[k] != 4'h0) begin
        owed_d[k] = owed_d[k] - 4'h1;
      end
    end
  end

  // Refresh-due flags let the scheduler keep the average interval
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (j = 0; j < RANKS; j = j + 1) begin
        owed_q[j] <= 4'h0;
      end
      refresh_due_q <= {RANKS{1'b0}};
    end else begin
      for (j = 0; j < RANKS; j = j + 1) begin
        owed_q[j] <= owed_d[j];
        refresh_due_q[j] <= (owed_d[j] != 4'h0);
      end
    end
  end
endmodule

// [dtg_guard_checker.sv]
// Port-level timing checks for the command spacing guard
`timescale 1ns/100ps
`include "dtg_map.vh"
module dtg_guard_checker #(
  parameter RW = 1,
  parameter GW = 2
) (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire cmd_valid,
  input wire [1:0] cmd_type,
  input wire issue_valid_q,
  input wire [1:0] issue_type_q,
  input wire [RW-1:0] issue_rank_q,
  input wire [GW-1:0] issue_group_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Issued command kinds
  wire is_act = issue_valid_q && issue_type_q == `DTG_CMD_ACT;
  wire is_rd = issue_valid_q && issue_type_q == `DTG_CMD_RD;
  wire is_wr = issue_valid_q && issue_type_q == `DTG_CMD_WR;
  wire is_ref = issue_valid_q && issue_type_q == `DTG_CMD_REF;
  wire apb_wr = psel && penable && pready && pwrite;
  // Cycles since the last command of each kind, saturating
  reg [7:0] act_gap_q, col_gap_q, wr_gap_q, ref_gap_q;
  reg [RW-1:0] act_rank_q, ref_rank_q;
  reg [GW-1:0] act_grp_q, col_grp_q, wr_grp_q;
  // Activate spacing and device window copied from register writes, so reprogramming them stays checked
  reg [7:0] rrd_s_q, rrd_l_q, rrd_x_q, fawx_q;
  // Free-running time and the times of the last four activates
  reg [15:0] cyc_q, ts0_q, ts1_q, ts2_q, ts3_q;
  function automatic [7:0] sat_inc(input [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  // History keeping; gaps start saturated so nothing is owed after reset
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {act_gap_q, col_gap_q, wr_gap_q, ref_gap_q} <= {4{8'hFF}};
      {act_rank_q, ref_rank_q, act_grp_q, col_grp_q, wr_grp_q} <= '0;
      {rrd_s_q, rrd_l_q, rrd_x_q} <= {`DTG_RST_RRD_S, `DTG_RST_RRD_L, `DTG_RST_RRD_X};
      fawx_q <= `DTG_RST_FAWX;
      cyc_q <= 16'h0100;
      {ts0_q, ts1_q, ts2_q, ts3_q} <= '0;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
      act_gap_q <= is_act ? 8'h01 : sat_inc(act_gap_q);
      col_gap_q <= (is_rd || is_wr) ? 8'h01 : sat_inc(col_gap_q);
      wr_gap_q <= is_wr ? 8'h01 : sat_inc(wr_gap_q);
      ref_gap_q <= is_ref ? 8'h01 : sat_inc(ref_gap_q);
      if (is_act) begin
        {act_rank_q, act_grp_q} <= {issue_rank_q, issue_group_q};
        {ts0_q, ts1_q, ts2_q, ts3_q} <= {cyc_q, ts0_q, ts1_q, ts2_q};
      end
      if (is_rd || is_wr) col_grp_q <= issue_group_q;
      if (is_wr) wr_grp_q <= issue_group_q;
      if (is_ref) ref_rank_q <= issue_rank_q;
      if (apb_wr && paddr == `DTG_OFF_ACT) begin
        {rrd_x_q, rrd_l_q, rrd_s_q} <= pwdata[23:0];
      end
      if (apb_wr && paddr == `DTG_OFF_FAW) fawx_q <= pwdata[15:8];
    end
  end
  issue_follows_req_a: assert property (issue_valid_q |-> !$past(issue_valid_q) &&
    $past(cmd_valid) && $past(cmd_type) == issue_type_q) else $error("issue without request");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  act_diff_group_a: assert property (is_act && issue_rank_q == act_rank_q &&
    issue_group_q != act_grp_q |-> act_gap_q >= rrd_s_q) else $error("act other group early");
  act_same_group_a: assert property (is_act && issue_rank_q == act_rank_q &&
    issue_group_q == act_grp_q |-> act_gap_q >= rrd_l_q) else $error("act same group early");
  act_diff_rank_a: assert property (is_act && issue_rank_q != act_rank_q |->
    act_gap_q >= rrd_x_q) else $error("act other rank early");
  act_window_a: assert property (is_act |-> cyc_q - ts3_q >= {8'h00, fawx_q})
    else $error("fifth act inside window");
  col_diff_group_a: assert property ((is_rd || is_wr) && issue_group_q != col_grp_q |->
    col_gap_q >= `DTG_RST_CCD_S) else $error("column other group early");
  col_same_group_a: assert property ((is_rd || is_wr) && issue_group_q == col_grp_q |->
    col_gap_q >= `DTG_RST_CCD_L) else $error("column same group early");
  rd_wr_diff_a: assert property (is_rd && issue_group_q != wr_grp_q |->
    wr_gap_q >= `DTG_RST_WEND + `DTG_RST_WTR_S) else $error("read after write early");
  rd_wr_same_a: assert property (is_rd && issue_group_q == wr_grp_q |->
    wr_gap_q >= `DTG_RST_WEND + `DTG_RST_WTR_L) else $error("read after write early");
  ref_act_rank_a: assert property (is_act && issue_rank_q == ref_rank_q |->
    ref_gap_q >= `DTG_RFC_CYC) else $error("act inside refresh cycle");
  ref_act_other_a: assert property (is_act && issue_rank_q != ref_rank_q |->
    ref_gap_q >= `DTG_RFCX_CYC) else $error("act inside cross-rank refresh");
endmodule
bind dtg_timing_guard dtg_guard_checker #(.RW(RW), .GW(GW)) u_dtg_guard_checker (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .cmd_valid(cmd_valid), .cmd_type(cmd_type), .issue_valid_q(issue_valid_q),
  .issue_type_q(issue_type_q), .issue_rank_q(issue_rank_q), .issue_group_q(issue_group_q));

// [dtg_sdram_model.sv]
// Behavioural memory device receiving the guarded command stream
`timescale 1ns/100ps
module dtg_sdram_model (
  input wire mclk,
  input wire nrst,
  input wire cmd_in,
  output reg [7:0] seen_count_q,
  output reg seen_tight_q
);
  reg prev_q; // Command present last cycle
  // Count commands; two in adjacent cycles cannot be decoded by the device
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_count_q <= 8'h00;
      seen_tight_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= cmd_in;
      if (cmd_in) seen_count_q <= seen_count_q + 8'h01;
      if (cmd_in && prev_q) seen_tight_q <= 1'b1;
    end
  end
endmodule

// [dtg_timing_guard_bench.sv]
// Self-checking bench for the command spacing guard
`timescale 1ns/100ps
`include "dtg_map.vh"
module dtg_timing_guard_bench;
  reg mclk, nrst, psel, penable, pwrite, cmd_valid, cmd_rank, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd_data;
  reg [1:0] cmd_type, cmd_group;
  wire [31:0] prdata;
  wire pready, pslverr, issue_valid_q, issue_rank_q, seen_tight;
  wire [1:0] issue_type_q, issue_group_q, refresh_due_q;
  wire [7:0] seen_count;
  int miscompares = 0, checked = 0, cyc = 0, sends = 0;
  int t0, t1, t2, t3, t4, n, i;
  // Rows: first type/rank/group, second type/rank/group, least gap
  reg [17:0] rows [0:8] = '{
    {2'h0, 1'h0, 2'h0, 2'h0, 1'h0, 2'h1, 8'h04}, {2'h0, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 8'h06},
    {2'h0, 1'h0, 2'h0, 2'h0, 1'h1, 2'h0, 8'h04}, {2'h1, 1'h0, 2'h0, 2'h1, 1'h0, 2'h1, 8'h04},
    {2'h2, 1'h0, 2'h0, 2'h2, 1'h0, 2'h0, 8'h06}, {2'h2, 1'h0, 2'h0, 2'h1, 1'h0, 2'h1, 8'h0F},
    {2'h2, 1'h0, 2'h0, 2'h1, 1'h0, 2'h0, 8'h14}, {2'h3, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 8'h23},
    {2'h3, 1'h0, 2'h0, 2'h0, 1'h1, 2'h0, 8'h0C}};
  // Register values after reset, by word address; the interval counter starts
  // expired, so status already owes one refresh per rank
  reg [31:0] rst_tab [0:7] = '{32'h00040604, 32'h00001003, 32'h00000604, 32'h000C0803,
    32'h000C0023, 32'h00000320, 32'h00010003, 32'h00000001};
  dtg_timing_guard #(.RW(1), .GW(2)) u_dtg_timing_guard (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd_type(cmd_type), .cmd_rank(cmd_rank), .cmd_group(cmd_group),
    .issue_valid_q(issue_valid_q), .issue_type_q(issue_type_q), .issue_rank_q(issue_rank_q),
    .issue_group_q(issue_group_q), .refresh_due_q(refresh_due_q));
  dtg_sdram_model u_dtg_sdram_model (.mclk(mclk), .nrst(nrst), .cmd_in(issue_valid_q),
    .seen_count_q(seen_count), .seen_tight_q(seen_tight));
  // Clock and cycle count; the count is read at edges, so it updates late
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready, then one idle edge before the next setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Present a command and hold it until the guard issues it
  task automatic send(input logic [1:0] t, input logic r, input logic [1:0] g, output int at);
    cmd_valid <= 1'b1;
    cmd_type <= t;
    cmd_rank <= r;
    cmd_group <= g;
    n = 0;
    do begin @(posedge mclk); n++; end while (issue_valid_q !== 1'b1 && n < 200);
    if (n >= 200) miscompares++;
    at = cyc;
    sends++;
    chk({issue_type_q, issue_rank_q, issue_group_q}, {t, r, g}, "issued fields");
  endtask
  task automatic idle();
    cmd_valid <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Guards against a hang; the whole run needs under a thousand cycles
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    {nrst, psel, penable, pwrite, cmd_valid, cmd_rank, cmd_type, cmd_group} = '0;
    {paddr, pwdata} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd_data, rst_tab[i], "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd_data, 32'h0, "unmapped read");
    // Stop refresh owing so the spacing cases run undisturbed
    apb(1'b1, `DTG_OFF_CTRL, 32'h0);
    for (i = 0; i < 9; i++) begin
      send(rows[i][17:16], rows[i][15], rows[i][14:13], t0);
      send(rows[i][12:11], rows[i][10], rows[i][9:8], t1);
      idle();
      chk(t1 - t0 >= rows[i][7:0] && t1 - t0 <= rows[i][7:0] + 2, 1, "gap");
    end
    // Short activate spacing so only the four-activate windows hold back
    apb(1'b1, `DTG_OFF_ACT, 32'h00020202);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `DTG_OFF_FAW, (i == 0) ? 32'h00001003 : 32'h00000214);
      send(2'h0, 1'h0, 2'h0, t0);
      send(2'h0, 1'h0, 2'h1, t1);
      send(2'h0, 1'h0, 2'h2, t2);
      send(2'h0, 1'h0, 2'h3, t3);
      send(2'h0, 1'h0, 2'h0, t4);
      idle();
      chk(t4 - t0 >= ((i == 0) ? 16 : 20), 1, "fifth act");
      chk(t3 - t0 <= 9, 1, "first four acts");
    end
    // Pay the debt left from reset, then let a short interval owe again; the
    // running count must first expire from its old load, hence the long wait
    send(2'h3, 1'h1, 2'h0, t0);
    idle();
    chk(refresh_due_q, 2'h0, "refresh clear");
    apb(1'b1, `DTG_OFF_REFI, 32'h00000014);
    apb(1'b1, `DTG_OFF_CTRL, 32'h00000001);
    n = 0;
    while (refresh_due_q !== 2'h3 && n < 900) begin @(posedge mclk); n++; end
    chk(refresh_due_q, 2'h3, "refresh due");
    apb(1'b1, `DTG_OFF_CTRL, 32'h0);
    apb(1'b0, `DTG_OFF_STAT, 32'h0);
    chk(rd_data & 32'h000F0003, 32'h00010003, "owed count");
    send(2'h3, 1'h0, 2'h0, t0);
    idle();
    chk(refresh_due_q, 2'h2, "refresh paid");
    chk(seen_count, sends[7:0], "device count");
    chk(seen_tight, 1'b0, "device spacing");
    // Mid-run reset brings the programmed spacing back to its default
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(issue_valid_q, 1'b0, "reset issue");
    nrst <= 1'b1;
    @(posedge mclk);
    apb(1'b0, `DTG_OFF_ACT, 32'h0);
    chk(rd_data, rst_tab[0], "reset spacing");
    close_out();
  end
endmodule
